// ### rtl/adcsrp_device.sv
// adcsrp_device: digital readout side of the converter, parallel and three-wire serial.
// assumes i_result arrives with i_conv_start; link pins come from another domain and are
// synchronised before use. a two-entry buffer holds finished results until a read takes them.
//
// Overview of operation
// - outside serial mode, shared pins carry parallel bits
// - external clock makes read-mode pin a chain input
// - chain input appears on output after 18 clocks
// - internal clock, mode high: shift during next conversion
// - internal clock, mode low: shift after conversion ends
// - result shifted out most significant bit first
// - format select picks offset binary or two's complement
// - internal clock: data changes at the internal clock's falling edge, stable across its rising edge
// - invert low, external clock: update rising, host samples falling
// - invert high, external clock: update falling, host samples rising
// - clock pin direction from source select, edge from invert
// - polarity low: frame sync high while data valid
// - polarity high: frame sync low while data valid
// - unfinished external read at next conversion: discard, flag pulse
// - bits 14 to 17 are always outputs
// - busy rises when a conversion starts
// - busy holds until result reaches the output buffer
// - drivers enabled only with chip select and read low, except the serial clock pin with internal clock
// - source select low: device drives serial clock
// - external clock ignored without chip select
`timescale 1ns/100ps
module adcsrp_device
  import adcsrp_pkg::*;
#(
  parameter int RES_BITS = ADCSRP_RES_BITS
) (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_conv_start,
  input wire logic [17:0] i_result,
  output logic o_in_ready,
  adcsrp_if.device_end port
);
  typedef enum logic [1:0] {
    ADCSRP_IDLE = 2'b00,
    ADCSRP_SHIFT = 2'b01,
    ADCSRP_DONE = 2'b11
  } adcsrp_sh_type;

  typedef struct packed {
    logic [1:0] s_cs, s_rd, s_mode, s_src, s_pol, s_inv, s_fmt, s_chain, s_sclk;
    logic sclk_prev;
    logic busy;
    logic [5:0] conv_cnt;
    logic [17:0] conv_res;
    logic [1:0][17:0] buf_data;
    logic [1:0] buf_valid;
    logic buf_wr, buf_rd;
    logic [17:0] shreg;
    logic [4:0] bit_cnt;
    logic first_upd;
    logic sel_prev;
    logic [2:0] div_cnt;
    logic sclk_int;
    adcsrp_sh_type sh;
    logic sdo;
    logic err;
    logic sync_act;
    logic [17:0] dout;
    logic [17:0] doe;
  } adcsrp_state_type;

  adcsrp_state_type r, next_r;

  // result coding: offset binary is the two's complement value with its sign flipped
  function automatic logic [17:0] adcsrp_encode(input logic [17:0] v, input logic fmt);
    adcsrp_encode = fmt ? v : (v ^ ADCSRP_SIGN_MASK);
  endfunction

  ////////////////////////////////////////////////////////////////////////////////////////////
  always_comb begin
    logic ext, sel, rise, fall, upd, smp, can_start, pop;
    logic [17:0] head;
    next_r = r;
    // two-flop synchronisers; only stage two is read
    next_r.s_cs = {r.s_cs[0], port.cs_n};
    next_r.s_rd = {r.s_rd[0], port.rd_n};
    next_r.s_mode = {r.s_mode[0], port.serial_mode};
    next_r.s_src = {r.s_src[0], port.clock_source_select};
    next_r.s_pol = {r.s_pol[0], port.frame_sync_polarity_select};
    next_r.s_inv = {r.s_inv[0], port.serial_clock_invert_select};
    next_r.s_fmt = {r.s_fmt[0], port.output_format_select};
    next_r.s_chain = {r.s_chain[0], port.read_mode_or_chain_input};
    next_r.s_sclk = {r.s_sclk[0], port.sclk_wire};
    next_r.sclk_prev = r.s_sclk[1];
    ext = r.s_src[1];
    sel = !r.s_cs[1] && !r.s_rd[1];
    rise = ext && !r.s_cs[1] && r.s_sclk[1] && !r.sclk_prev;
    fall = ext && !r.s_cs[1] && !r.s_sclk[1] && r.sclk_prev;
    upd = r.s_inv[1] ? fall : rise;
    smp = r.s_inv[1] ? rise : fall;
    next_r.sel_prev = sel;
    next_r.err = 1'b0;
    next_r.buf_wr = r.buf_wr;
    next_r.buf_rd = r.buf_rd;
    head = r.buf_data[r.buf_rd];
    pop = 1'b0;
    // conversion timer; busy rises on start and falls once the result is stored
    if (i_conv_start && !r.busy) begin
      next_r.busy = 1'b1;
      next_r.conv_cnt = ADCSRP_CONV_M1;
      next_r.conv_res = i_result;
    end else if (r.busy && r.conv_cnt != '0) begin
      next_r.conv_cnt = r.conv_cnt - 6'h01;
    end else if (r.busy && !r.buf_valid[r.buf_wr]) begin
      // busy stalls here while the buffer is full, so no result is lost
      next_r.busy = 1'b0;
      next_r.buf_data[r.buf_wr] = adcsrp_encode(r.conv_res, r.s_fmt[1]);
      next_r.buf_valid[r.buf_wr] = 1'b1;
      next_r.buf_wr = !r.buf_wr;
      // external read still open when the next result lands: drop it, pulse the flag
      if (ext && r.sh == ADCSRP_SHIFT) begin
        // park until the host lets go, so the new word is not started mid-frame
        next_r.sh = ADCSRP_DONE;
        next_r.err = 1'b1;
      end
    end
    // internal read mode: high reads during conversion, low only after it finishes
    can_start = ext ? 1'b1 : (r.s_chain[1] || !r.busy);
    // serial shifter
    unique case (r.sh)
      ADCSRP_IDLE: begin
        next_r.sclk_int = 1'b0;
        next_r.div_cnt = ADCSRP_HALF_M1;
        if (r.s_mode[1] && sel && r.buf_valid[r.buf_rd] && can_start) begin
          next_r.shreg = head;
          pop = 1'b1;
          next_r.sdo = head[RES_BITS-1];
          next_r.bit_cnt = ADCSRP_CNT_ZERO;
          next_r.first_upd = 1'b1;
          next_r.sh = ADCSRP_SHIFT;
        end
      end
      ADCSRP_SHIFT: begin
        if (!ext) begin
          // internal clock from a divider; data changes only at the low-going edge
          // after a full high phase, so it is stable across the rising edge
          if (r.div_cnt != '0) begin
            next_r.div_cnt = r.div_cnt - 3'h1;
          end else begin
            next_r.div_cnt = ADCSRP_HALF_M1;
            next_r.sclk_int = !r.sclk_int;
            if (r.sclk_int) begin
              next_r.shreg = {r.shreg[16:0], 1'b0};
              next_r.sdo = r.shreg[16];
              next_r.bit_cnt = r.bit_cnt + ADCSRP_CNT_ONE;
              if (r.bit_cnt == ADCSRP_BITS_M1) begin
                next_r.sh = ADCSRP_DONE;
              end
            end
          end
        end else if (upd && r.first_upd) begin
          // the msb is already on the pin; the first update edge only opens the frame
          next_r.first_upd = 1'b0;
        end else if (upd) begin
          // chained input shifts in behind the result and leaves 18 clocks later
          next_r.shreg = {r.shreg[16:0], r.s_chain[1]};
          next_r.sdo = r.shreg[16];
          if (r.bit_cnt != ADCSRP_BITS_M1) begin
            next_r.bit_cnt = r.bit_cnt + ADCSRP_CNT_ONE;
          end
        end else if (smp && r.bit_cnt == ADCSRP_BITS_M1 && r.s_cs[1]) begin
          next_r.sh = ADCSRP_DONE;
        end
        if (!sel) begin
          next_r.sh = ADCSRP_IDLE;
        end
      end
      ADCSRP_DONE: begin
        next_r.sclk_int = 1'b0;
        if (!sel) begin
          next_r.sh = ADCSRP_IDLE;
        end
      end
      default: next_r.sh = ADCSRP_IDLE;
    endcase
    if (pop) begin
      next_r.buf_valid[r.buf_rd] = 1'b0;
      next_r.buf_rd = !r.buf_rd;
    end
    // parallel read retires the head word when the select window closes
    if (!r.s_mode[1] && r.sel_prev && !sel && r.buf_valid[r.buf_rd] && !pop) begin
      next_r.buf_valid[r.buf_rd] = 1'b0;
      next_r.buf_rd = !r.buf_rd;
    end
    next_r.sync_act = (r.sh == ADCSRP_SHIFT) && !ext;
    // pin drive
    if (!r.s_mode[1]) begin
      next_r.dout = head;
      next_r.doe = sel ? '1 : ADCSRP_ZERO;
    end else begin
      next_r.dout = ADCSRP_ZERO;
      next_r.dout[ADCSRP_PAR_MSB:ADCSRP_UPPER_LSB] = head[ADCSRP_PAR_MSB:ADCSRP_UPPER_LSB];
      next_r.dout[ADCSRP_BIT_SDO] = r.sdo;
      next_r.dout[ADCSRP_BIT_SCLK] = r.sclk_int ^ r.s_inv[1];
      next_r.dout[ADCSRP_BIT_SYNC] = r.sync_act ^ r.s_pol[1];
      next_r.dout[ADCSRP_BIT_ERR] = r.err;
      next_r.doe = ADCSRP_ZERO;
      next_r.doe[ADCSRP_PAR_MSB:ADCSRP_UPPER_LSB] = sel ? 4'hF : 4'h0;
      next_r.doe[ADCSRP_BIT_SDO] = sel;
      next_r.doe[ADCSRP_BIT_SCLK] = !ext;
      next_r.doe[ADCSRP_BIT_SYNC] = sel && !ext;
      next_r.doe[ADCSRP_BIT_ERR] = sel && ext;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////////
  // single state register
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign port.data_out = r.dout;
  assign port.data_oe = r.doe;
  assign port.busy = r.busy;
  assign o_in_ready = !r.busy;
endmodule

// ### rtl/adcsrp_host.sv
// adcsrp_host: host end; starts a serial read and returns the assembled word.
// assumes the converter end on the same interface; pins from it are synchronised.
`timescale 1ns/100ps
module adcsrp_host
  import adcsrp_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_read,
  input wire logic i_ext_clk,
  input wire logic i_mode_high,
  output logic [17:0] o_word,
  output logic o_word_valid,
  adcsrp_if.host_end port
);
  typedef struct packed {
    logic [1:0] s_sdo, s_sclk;
    logic sclk_prev;
    logic active;
    logic sclk;
    logic [2:0] div;
    logic [4:0] cnt;
    logic [17:0] sh;
    logic [17:0] word;
    logic valid;
  } adcsrp_hstate_type;

  adcsrp_hstate_type r, next_r;

  // host clock phase twice the device's: the device needs 4 cycles from a pin edge to new sdo
  localparam logic [2:0] HOST_HALF_M1 = 3'(2 * ADCSRP_SCLK_HALF - 1);

  ////////////////////////////////////////////////////////////////////////////////////////////
  always_comb begin
    logic smp;
    next_r = r;
    next_r.valid = 1'b0;
    next_r.s_sdo = {r.s_sdo[0], port.data_out[ADCSRP_BIT_SDO]};
    next_r.s_sclk = {r.s_sclk[0], port.sclk_wire};
    next_r.sclk_prev = r.s_sclk[1];
    // sample on the edge opposite to the device's update edge
    // external clock: device updates on rise, so take the bit on the fall
    smp = i_ext_clk ? (!r.s_sclk[1] && r.sclk_prev) : (r.s_sclk[1] && !r.sclk_prev);
    if (!r.active && i_read) begin
      next_r.active = 1'b1;
      next_r.cnt = ADCSRP_CNT_ZERO;
      next_r.div = HOST_HALF_M1;
    end else if (r.active) begin
      if (i_ext_clk) begin
        // host-made clock: slow enough that the device's synchronisers see each phase
        if (r.div != '0) begin
          next_r.div = r.div - 3'h1;
        end else begin
          next_r.div = HOST_HALF_M1;
          next_r.sclk = !r.sclk;
        end
      end
      if (smp) begin
        next_r.sh = {r.sh[16:0], r.s_sdo[1]};
        next_r.cnt = r.cnt + ADCSRP_CNT_ONE;
        if (r.cnt == ADCSRP_BITS_M1) begin
          next_r.active = 1'b0;
          next_r.sclk = 1'b0;
          next_r.word = {r.sh[16:0], r.s_sdo[1]};
          next_r.valid = 1'b1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  // select lines held asserted only during a read
  assign port.cs_n = !r.active;
  assign port.rd_n = !r.active;
  assign port.serial_mode = 1'b1;
  assign port.clock_source_select = i_ext_clk;
  assign port.frame_sync_polarity_select = 1'b0;
  assign port.serial_clock_invert_select = 1'b0;
  assign port.output_format_select = 1'b1;
  assign port.read_mode_or_chain_input = i_ext_clk ? 1'b0 : i_mode_high;
  assign port.host_sclk = r.sclk;
  assign port.host_sclk_oe = i_ext_clk;
  assign o_word = r.word;
  assign o_word_valid = r.valid;
endmodule

// ### rtl/adcsrp_if.sv
// adcsrp_if: the converter's pins as seen between converter end and host end.
// assumes the bench ties each wire; the serial clock pin is resolved here from both enables.
`timescale 1ns/100ps
interface adcsrp_if;
  logic [17:0] data_out;
  logic [17:0] data_oe;
  logic cs_n;
  logic rd_n;
  logic busy;
  logic serial_mode;
  logic clock_source_select;
  logic frame_sync_polarity_select;
  logic serial_clock_invert_select;
  logic output_format_select;
  logic read_mode_or_chain_input;
  logic host_sclk;
  logic host_sclk_oe;
  logic sclk_wire;
  // serial clock pin: device drive wins while its enable is high, else host drive
  assign sclk_wire = data_oe[11] ? data_out[11] : (host_sclk_oe ? host_sclk : 1'b0);
  modport device_end (
    output data_out, data_oe, busy,
    input cs_n, rd_n, serial_mode, clock_source_select, frame_sync_polarity_select,
    serial_clock_invert_select, output_format_select, read_mode_or_chain_input, sclk_wire
  );
  modport host_end (
    input data_out, data_oe, busy, sclk_wire,
    output cs_n, rd_n, serial_mode, clock_source_select, frame_sync_polarity_select,
    serial_clock_invert_select, output_format_select, read_mode_or_chain_input,
    host_sclk, host_sclk_oe
  );
endinterface

// ### rtl/adcsrp_pkg.sv
// adcsrp_pkg: constants for the converter's readout port, shared by both ends.
// assumes a single 25 MHz system clock in each end; the link pins are sampled, not clocked.
package adcsrp_pkg;
  localparam int ADCSRP_RES_BITS = 18;
  localparam int ADCSRP_CHAIN_DELAY = 18;
  localparam int ADCSRP_SYS_CLK_MHZ = 25;
  localparam int ADCSRP_CONV_TIME_NS = 1000;
  localparam int ADCSRP_CONV_CYCLES = (ADCSRP_CONV_TIME_NS * ADCSRP_SYS_CLK_MHZ + 999) / 1000;
  localparam int ADCSRP_SCLK_HALF = 4;
  localparam int ADCSRP_PAR_MSB = 17;
  localparam int ADCSRP_UPPER_LSB = 14;
  localparam int ADCSRP_BIT_CHAIN = 9;
  localparam int ADCSRP_BIT_SDO = 10;
  localparam int ADCSRP_BIT_SCLK = 11;
  localparam int ADCSRP_BIT_SYNC = 12;
  localparam int ADCSRP_BIT_ERR = 13;
  localparam logic [17:0] ADCSRP_SIGN_MASK = 18'h20000;
  localparam logic [17:0] ADCSRP_ZERO = 18'h00000;
  localparam logic [4:0] ADCSRP_CNT_ZERO = 5'h00;
  localparam logic [4:0] ADCSRP_CNT_ONE = 5'h01;
  localparam logic [4:0] ADCSRP_BITS_M1 = 5'h11;
  localparam logic [5:0] ADCSRP_CONV_M1 = 6'(ADCSRP_CONV_CYCLES - 1);
  localparam logic [2:0] ADCSRP_HALF_M1 = 3'(ADCSRP_SCLK_HALF - 1);
endpackage

// ### sim/adc_serial_readout_port_tb.sv
// adc_serial_readout_port_tb: converter end and host end joined by one interface.
// assumes the host end makes any external serial clock itself; inputs change at the falling edge.
`timescale 1ns/100ps
module adc_serial_readout_port_tb;
  import adcsrp_pkg::*;
  logic sys_clk;
  logic rst;
  logic conv_start;
  logic [17:0] result;
  logic in_ready;
  logic read;
  logic ext_clk;
  logic mode_high;
  logic [17:0] word;
  logic word_valid;
  int err_total;
  int compares;
  adcsrp_if bus();
  ////////////////////////////////////////
  // both ends and the pin checker
  adcsrp_device u_adcsrp_device (.i_sys_clk(sys_clk), .i_rst(rst), .i_conv_start(conv_start),
    .i_result(result), .o_in_ready(in_ready), .port(bus));
  adcsrp_host u_adcsrp_host (.i_sys_clk(sys_clk), .i_rst(rst), .i_read(read),
    .i_ext_clk(ext_clk), .i_mode_high(mode_high), .o_word(word), .o_word_valid(word_valid),
    .port(bus));
  adcsrp_asserts u_adcsrp_asserts (.i_sys_clk(sys_clk), .i_rst(rst),
    .data_out(bus.data_out), .data_oe(bus.data_oe), .cs_n(bus.cs_n), .rd_n(bus.rd_n),
    .busy(bus.busy), .serial_mode(bus.serial_mode),
    .clock_source_select(bus.clock_source_select),
    .frame_sync_polarity_select(bus.frame_sync_polarity_select),
    .serial_clock_invert_select(bus.serial_clock_invert_select), .sclk_wire(bus.sclk_wire));
  ////////////////////////////////////////
  // 25 MHz system clock
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  // shared compare; x on the design side never matches
  task automatic check(input logic [17:0] got, input logic [17:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // verdict and end of run, also reached from the watchdog
  task automatic end_sim();
    $display("compares=%0d err_total=%0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  ////////////////////////////////////////
  // mode levels settle through the host before any request
  task automatic set_mode(input logic e, input logic m);
    ext_clk = e;
    mode_high = m;
    repeat (4) @(negedge sys_clk);
  endtask
  // one-cycle start; busy must already be up one edge later
  task automatic convert(input logic [17:0] v);
    result = v;
    conv_start = 1'b1;
    @(negedge sys_clk);
    conv_start = 1'b0;
    check({17'h00000, bus.busy}, 18'h00001);
  endtask
  task automatic wait_ready();
    int n;
    n = 0;
    while (in_ready !== 1'b1 && n < 600) begin
      @(negedge sys_clk);
      n++;
    end
    if (n >= 600) begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, in_ready, 1'b1);
    end
  endtask
  // a missing word times out and shows up as a mismatch
  task automatic read_check(input logic [17:0] exp);
    int n;
    n = 0;
    read = 1'b1;
    @(negedge sys_clk);
    read = 1'b0;
    while (word_valid !== 1'b1 && n < 2000) begin
      @(negedge sys_clk);
      n++;
    end
    check(word, exp);
  endtask
  ////////////////////////////////////////
  // internal clock, read only after the conversion ends
  task automatic t_int_after();
    set_mode(1'b0, 1'b0);
    convert(18'h2D4B1);
    wait_ready();
    read_check(18'h2D4B1);
  endtask
  // host-made clock
  task automatic t_ext_read();
    set_mode(1'b1, 1'b0);
    convert(18'h1C3A5);
    wait_ready();
    read_check(18'h1C3A5);
  endtask
  // fill both entries, stall a third conversion, drain in order
  task automatic t_buffer();
    set_mode(1'b0, 1'b1);
    convert(18'h3F00F);
    wait_ready();
    convert(18'h00FF0);
    wait_ready();
    convert(18'h15A5A);
    repeat (60) @(negedge sys_clk);
    check({17'h00000, bus.busy}, 18'h00001);
    read_check(18'h3F00F);
    read_check(18'h00FF0);
    wait_ready();
    read_check(18'h15A5A);
  endtask
  // a new result lands while an external read is still shifting
  task automatic t_error();
    logic seen;
    set_mode(1'b1, 1'b0);
    convert(18'h2AAAA);
    wait_ready();
    read = 1'b1;
    @(negedge sys_clk);
    read = 1'b0;
    repeat (30) @(negedge sys_clk);
    convert(18'h05555);
    seen = 1'b0;
    for (int n = 0; n < 200; n++) begin
      @(negedge sys_clk);
      seen = seen | bus.data_out[13];
    end
    check({17'h00000, seen}, 18'h00001);
  endtask
  ////////////////////////////////////////
  // main sequence: reset for 3 cycles, then the scenarios
  initial begin
    rst = 1'b1;
    conv_start = 1'b0;
    result = 18'h00000;
    read = 1'b0;
    ext_clk = 1'b0;
    mode_high = 1'b0;
    err_total = 0;
    compares = 0;
    repeat (3) @(negedge sys_clk);
    rst = 1'b0;
    repeat (4) @(negedge sys_clk);
    t_int_after();
    t_ext_read();
    t_buffer();
    t_error();
    end_sim();
  end
  // watchdog: the scenarios need well under 5000 cycles
  initial begin
    repeat (20000) @(posedge sys_clk);
    err_total++;
    end_sim();
  end
endmodule

// ### sim/adcsrp_asserts.sv
// adcsrp_asserts: timing checks on the pins between converter end and host end.
// assumes one system clock; fed straight from the interface signals, no bind.
`timescale 1ns/100ps
module adcsrp_asserts (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic [17:0] data_out,
  input wire logic [17:0] data_oe,
  input wire logic cs_n,
  input wire logic rd_n,
  input wire logic busy,
  input wire logic serial_mode,
  input wire logic clock_source_select,
  input wire logic frame_sync_polarity_select,
  input wire logic serial_clock_invert_select,
  input wire logic sclk_wire
);
  // one clock domain, so clock and reset are given once
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (i_rst);
  // which side makes the serial clock
  wire logic ext_mode = serial_mode & clock_source_select;
  wire logic int_mode = serial_mode & ~clock_source_select;
  ////////////////////////////////////////
  // a conversion holds busy for at least 24 cycles
  sequence s_conv_hold;
    busy[*8] ##1 busy[*8] ##1 busy[*8];
  endsequence
  // stalls behind a full buffer may stretch busy, hence the wide bound
  sequence s_conv_done;
    ##[1:600] !busy;
  endsequence
  property p_busy_hold;
    $rose(busy) |-> s_conv_hold;
  endproperty
  a_busy_hold: assert property (p_busy_hold) else $error("busy fell early");
  property p_busy_fall;
    $rose(busy) |-> s_conv_hold ##0 s_conv_done;
  endproperty
  a_busy_fall: assert property (p_busy_fall) else $error("busy stuck");
  // sdo driver off once the read is released; 4 cycles cover the synchronisers
  property p_tristate;
    (cs_n || rd_n)[*4] |-> !data_oe[10];
  endproperty
  a_tristate: assert property (p_tristate) else $error("sdo driven");
  property p_ext_no_drive;
    ext_mode[*4] |-> !data_oe[11];
  endproperty
  a_ext_no_drive: assert property (p_ext_no_drive) else $error("sclk clash");
  property p_int_drive;
    (int_mode && !cs_n && !rd_n)[*4] |-> data_oe[11];
  endproperty
  a_int_drive: assert property (p_int_drive) else $error("sclk not driven");
  property p_err_pulse;
    ext_mode && $rose(data_out[13]) |=> !data_out[13];
  endproperty
  a_err_pulse: assert property (p_err_pulse) else $error("error flag long");
  // sdo may only move while the clock sits in its update phase
  property p_upd_rise;
    ext_mode && !serial_clock_invert_select && !cs_n && !$past(cs_n, 8)
      && $changed(data_out[10]) |-> sclk_wire;
  endproperty
  a_upd_rise: assert property (p_upd_rise) else $error("sdo moved in low phase");
  property p_upd_fall;
    ext_mode && serial_clock_invert_select && !cs_n && !$past(cs_n, 8)
      && $changed(data_out[10]) |-> !sclk_wire;
  endproperty
  a_upd_fall: assert property (p_upd_fall) else $error("sdo moved in high phase");
  property p_int_stable;
    int_mode && $rose(sclk_wire) |-> $stable(data_out[10]);
  endproperty
  a_int_stable: assert property (p_int_stable) else $error("sdo moved at edge");
  property p_sync_pol;
    int_mode && $rose(sclk_wire) |-> data_out[12] != frame_sync_polarity_select;
  endproperty
  a_sync_pol: assert property (p_sync_pol) else $error("sync inactive");
endmodule
